// >>> pkg/cfg_handshake_pkg.sv
package cfg_handshake_pkg;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_LOAD,
		ST_ERROR,
		ST_INIT,
		ST_USER
	} cfg_state_e;

	// Serial memory read command and frame sizes
	localparam logic [7:0]  READ_CMD      = 8'h03;
	localparam int          CMD_BITS      = 8;
	localparam int          ADDR_BITS     = 24;
	localparam logic [23:0] START_ADDR    = 24'h000000;
	localparam int          HDR_BITS      = CMD_BITS + ADDR_BITS;
	localparam int          BIT_CNT_W     = 32;
	// Configuration image length in bits and init cycles
	localparam logic [31:0] IMAGE_BITS    = 32'h00000100;
	localparam logic [7:0]  INIT_CYCLES   = 8'h10;
	// Reset values of pin-facing flops
	localparam logic        CE_OUT_RST    = 1'b1;
	localparam logic        SEL_OUT_RST   = 1'b1;
	localparam logic        CMD_OUT_RST   = 1'b1;
	localparam logic        LINE_OE_RST   = 1'b1;

endpackage

// >>> core/cfg_cmd_shifter.sv
module cfg_cmd_shifter
	import cfg_handshake_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Control
	input  wire logic load_i,
	input  wire logic shift_i,
	// Serial out
	output logic      bit_o
);

	logic [HDR_BITS-1:0] shift_r;

	// Command then start address, MSB first
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_r <= '1;
		end else if (ce_i) begin
			if (load_i) begin
				shift_r <= {READ_CMD, START_ADDR};
			end else if (shift_i) begin
				shift_r <= {shift_r[HDR_BITS-2:0], 1'b1};
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_o <= CMD_OUT_RST;
		end else if (ce_i) begin
			bit_o <= shift_i ? shift_r[HDR_BITS-1] : CMD_OUT_RST;
		end
	end

endmodule

// >>> core/config_status_chain_handshake.sv
// Behaviour
// - The done line is driven low from reset and throughout loading.
// - The done line is released once all data arrived without error and initialization starts.
// - When the done line reads high after loading, initialization runs and user mode follows.
// - In user mode a low done line is ignored and the configured state is unchanged.
// - The chain enable input is active low and loading proceeds only while it is low.
// - The chain enable output goes low once this device's configuration is complete.
// - In active serial mode the command output sends the read request to the serial memory.
// - In active serial mode the select output enables the serial memory while it is accessed.
// - An error during loading pulls the status line low and halts loading.
// - A low restart input discards configuration and resets; its rising edge starts reconfiguration.
module config_status_chain_handshake
	import cfg_handshake_pkg::*;
(
	// Clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Mode and control pins
	input  wire logic active_serial_mode_i,
	input  wire logic config_restart_i,
	input  wire logic chain_enable_in_n_i,
	// Configuration data
	input  wire logic data_valid_i,
	input  wire logic data_error_i,
	// Done line, open drain
	input  wire logic config_done_line_i,
	output logic      config_done_line_o,
	output logic      config_done_line_oe_o,
	// Status line, open drain
	input  wire logic status_error_line_i,
	output logic      status_error_line_o,
	output logic      status_error_line_oe_o,
	// Chain and serial memory
	output logic      chain_enable_out_n_o,
	output logic      flash_select_out_n_o,
	output logic      serial_cmd_out_o,
	output logic      user_mode_o
);

	cfg_state_e            state_r;
	cfg_state_e            state_nxt;
	logic [BIT_CNT_W-1:0]  bit_cnt_r;
	logic [7:0]            init_cnt_r;
	logic                  restart_d_r;
	logic                  hdr_load;
	logic                  hdr_shift;
	logic                  hdr_done;
	logic                  data_done;
	logic                  load_enabled;

	function automatic logic count_reached(input logic [BIT_CNT_W-1:0] cnt, input logic [BIT_CNT_W-1:0] lim);
		count_reached = (cnt >= lim);
	endfunction

	assign load_enabled = !chain_enable_in_n_i;
	assign hdr_done     = count_reached(bit_cnt_r, BIT_CNT_W'(HDR_BITS));
	assign data_done    = count_reached(bit_cnt_r, BIT_CNT_W'(HDR_BITS) + IMAGE_BITS);
	assign hdr_load     = (state_r == ST_RESET) && (state_nxt == ST_LOAD);
	assign hdr_shift    = (state_r == ST_LOAD) && (state_nxt == ST_LOAD) && active_serial_mode_i
		&& load_enabled && !hdr_done;

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				if (config_restart_i && !restart_d_r) begin
					state_nxt = ST_LOAD;
				end else if (config_restart_i && load_enabled) begin
					state_nxt = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (data_error_i || !status_error_line_i) begin
					state_nxt = ST_ERROR;
				end else if (data_done) begin
					state_nxt = ST_INIT;
				end
			end
			ST_INIT: begin
				if (!status_error_line_i) begin
					state_nxt = ST_ERROR;
				end else if (config_done_line_i && init_cnt_r >= INIT_CYCLES) begin
					state_nxt = ST_USER;
				end
			end
			ST_ERROR: begin
				state_nxt = ST_ERROR;
			end
			ST_USER: begin
				state_nxt = ST_USER;
			end
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
		if (!config_restart_i) begin
			state_nxt = ST_RESET;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_RESET;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// Restart edge detect
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			restart_d_r <= 1'b1;
		end else if (ce_i) begin
			restart_d_r <= config_restart_i;
		end
	end

	// Bit counter: header bits in AS, then data bits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_cnt_r <= '0;
		end else if (ce_i) begin
			if (state_r != ST_LOAD) begin
				bit_cnt_r <= active_serial_mode_i ? '0 : BIT_CNT_W'(HDR_BITS);
			end else if (load_enabled) begin
				if (hdr_shift || (hdr_done && data_valid_i)) begin
					bit_cnt_r <= bit_cnt_r + 1'b1;
				end
			end
		end
	end

	// Initialization counter, only advances once the line is high
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			init_cnt_r <= '0;
		end else if (ce_i) begin
			if (state_r != ST_INIT) begin
				init_cnt_r <= '0;
			end else if (config_done_line_i && init_cnt_r < INIT_CYCLES) begin
				init_cnt_r <= init_cnt_r + 1'b1;
			end
		end
	end

	// Done line drive
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_done_line_oe_o <= LINE_OE_RST;
		end else if (ce_i) begin
			config_done_line_oe_o <= !(state_nxt == ST_INIT || state_nxt == ST_USER);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_done_line_o <= 1'b0;
		end else if (ce_i) begin
			config_done_line_o <= 1'b0;
		end
	end

	// Status line drive
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_error_line_oe_o <= LINE_OE_RST;
		end else if (ce_i) begin
			status_error_line_oe_o <= (state_nxt == ST_ERROR) || !config_restart_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_error_line_o <= 1'b0;
		end else if (ce_i) begin
			status_error_line_o <= 1'b0;
		end
	end

	// Chain enable output
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			chain_enable_out_n_o <= CE_OUT_RST;
		end else if (ce_i) begin
			chain_enable_out_n_o <= (state_nxt != ST_USER);
		end
	end

	// Serial memory select
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_select_out_n_o <= SEL_OUT_RST;
		end else if (ce_i) begin
			flash_select_out_n_o <= !(active_serial_mode_i && state_nxt == ST_LOAD && load_enabled);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			user_mode_o <= 1'b0;
		end else if (ce_i) begin
			user_mode_o <= (state_nxt == ST_USER);
		end
	end

	cfg_cmd_shifter u_cmd (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.load_i  (hdr_load),
		.shift_i (hdr_shift),
		.bit_o   (serial_cmd_out_o)
	);

endmodule

// >>> dv/cfg_flash_model.sv
module cfg_flash_model
	import cfg_handshake_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Device side
	input  wire logic                sel_n_i,
	input  wire logic                cmd_i,
	input  wire logic                ps_valid_i,
	// Data toward device
	output logic                     valid_o,
	output logic [HDR_BITS-1:0]      hdr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] n_r;
	// Header starts at first low bit
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			n_r <= '0;
			hdr_o <= '0;
		end else if (sel_n_i) begin
			n_r <= '0;
		end else if (n_r < 6'(HDR_BITS) && !(n_r == 6'h00 && cmd_i)) begin
			hdr_o <= {hdr_o[HDR_BITS-2:0], cmd_i};
			n_r <= n_r + 6'h01;
		end
	end
	assign valid_o = sel_n_i ? ps_valid_i : (n_r == 6'(HDR_BITS));
endmodule

// >>> dv/cfg_hs_monitor.sv
module cfg_hs_monitor
	import cfg_handshake_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic active_serial_mode_i,
	input  wire logic config_restart_i,
	input  wire logic config_done_line_i,
	input  wire logic config_done_line_oe_o,
	input  wire logic status_error_line_oe_o,
	input  wire logic chain_enable_out_n_o,
	input  wire logic flash_select_out_n_o,
	input  wire logic serial_cmd_out_o,
	input  wire logic user_mode_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_CHAIN_OUT: assert property (!chain_enable_out_n_o |-> user_mode_o)
		else $error("chain out low outside user mode");
	AST_DONE_REL: assert property (user_mode_o |-> !config_done_line_oe_o)
		else $error("done held low in user mode");
	AST_RESTART: assert property (!config_restart_i && ce_i |=> !user_mode_o && chain_enable_out_n_o)
		else $error("restart ignored");
	AST_INIT_DONE: assert property ($rose(user_mode_o) |-> $past(config_done_line_i))
		else $error("user mode without done high");
	AST_USER_KEEP: assert property (user_mode_o && config_restart_i && ce_i |=> user_mode_o)
		else $error("user mode lost");
	AST_SEL_AS: assert property (!flash_select_out_n_o |-> active_serial_mode_i && !user_mode_o)
		else $error("select low outside serial load");
	AST_CMD_IDLE: assert property (flash_select_out_n_o |-> serial_cmd_out_o)
		else $error("command line active while deselected");
	AST_DONE_LOAD: assert property (!user_mode_o && !config_done_line_oe_o && !status_error_line_oe_o
		|-> flash_select_out_n_o)
		else $error("done released during load");
	cover property ($rose(user_mode_o));
	cover property ($rose(status_error_line_oe_o) && config_restart_i);
	cover property ($fell(flash_select_out_n_o));
endmodule
bind config_status_chain_handshake cfg_hs_monitor u_mon (.clk_i, .rst_i, .ce_i, .active_serial_mode_i,
	.config_restart_i, .config_done_line_i, .config_done_line_oe_o, .status_error_line_oe_o,
	.chain_enable_out_n_o, .flash_select_out_n_o, .serial_cmd_out_o, .user_mode_o);

// >>> dv/config_status_chain_handshake_tb.sv
module config_status_chain_handshake_tb
	import cfg_handshake_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, ce_i = 1, active_serial_mode_i = 1, config_restart_i = 0;
	logic chain_enable_in_n_i = 0, data_error_i = 0, ext_d = 0, ext_s = 0, ps_v = 0;
	logic data_valid_i, config_done_line_o, config_done_line_oe_o, status_error_line_o;
	logic status_error_line_oe_o, chain_enable_out_n_o, flash_select_out_n_o, serial_cmd_out_o, user_mode_o;
	logic [HDR_BITS-1:0] hdr;
	int n_fail = 0, checks_done = 0;
	// Open-drain wires with pull-up
	wire config_done_line_i = !(config_done_line_oe_o | ext_d);
	wire status_error_line_i = !(status_error_line_oe_o | ext_s);
	config_status_chain_handshake DUT (.clk_i, .rst_i, .ce_i, .active_serial_mode_i, .config_restart_i,
		.chain_enable_in_n_i, .data_valid_i, .data_error_i, .config_done_line_i, .config_done_line_o,
		.config_done_line_oe_o, .status_error_line_i, .status_error_line_o, .status_error_line_oe_o,
		.chain_enable_out_n_o, .flash_select_out_n_o, .serial_cmd_out_o, .user_mode_o);
	cfg_flash_model FM (.clk_i, .rst_i, .sel_n_i(flash_select_out_n_o), .cmd_i(serial_cmd_out_o),
		.ps_valid_i(ps_v), .valid_o(data_valid_i), .hdr_o(hdr));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task restart();
		config_restart_i <= 0;
		cyc(2);
		config_restart_i <= 1;
	endtask
	task wait_user();
		int i;
		for (i = 0; i < 2000 && user_mode_o !== 1'b1; i++) @(negedge clk_i);
		if (i == 2000) begin
			n_fail++;
			conclude();
		end
	endtask
	task t_as();
		restart();
		cyc(4);
		@(negedge clk_i);
		chk(config_done_line_oe_o, 1);
		chk(flash_select_out_n_o, 0);
		wait_user();
		chk(hdr, {READ_CMD, START_ADDR});
		chk(chain_enable_out_n_o, 0);
		chk(config_done_line_oe_o, 0);
		chk(config_done_line_o, 0);
		chk(status_error_line_o, 0);
		$display("test as_load done");
	endtask
	task t_hold();
		cyc(1);
		ext_d <= 1;
		ext_s <= 1;
		cyc(10);
		@(negedge clk_i);
		chk(user_mode_o, 1);
		cyc(1);
		ext_d <= 0;
		ext_s <= 0;
		ce_i <= 0;
		config_restart_i <= 0;
		cyc(3);
		@(negedge clk_i);
		chk(user_mode_o, 1);
		cyc(1);
		ce_i <= 1;
		chain_enable_in_n_i <= 1;
		cyc(2);
		@(negedge clk_i);
		chk(user_mode_o, 0);
		chk(chain_enable_out_n_o, 1);
		$display("test user_hold done");
	endtask
	task t_stall();
		cyc(1);
		config_restart_i <= 1;
		cyc(400);
		@(negedge clk_i);
		chk(user_mode_o, 0);
		chk(chain_enable_out_n_o, 1);
		cyc(1);
		chain_enable_in_n_i <= 0;
		wait_user();
		chk(chain_enable_out_n_o, 0);
		$display("test chain_stall done");
	endtask
	task t_err();
		cyc(1);
		active_serial_mode_i <= 0;
		ps_v <= 1;
		restart();
		cyc(20);
		data_error_i <= 1;
		cyc(1);
		data_error_i <= 0;
		@(negedge clk_i);
		chk(status_error_line_oe_o, 1);
		cyc(300);
		@(negedge clk_i);
		chk(user_mode_o, 0);
		restart();
		wait_user();
		chk(chain_enable_out_n_o, 0);
		$display("test error_halt done");
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		t_as();
		t_hold();
		t_stall();
		t_err();
		conclude();
	end
endmodule
